// ===== src/ccd_cfg_debug.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - configuration is 32 bits, eight bits live
// - bits 4-7 read one, writes ignored
// - set-config loads 0, 1 and 3, clears 2 and 8-12
// - bit 0 selects vectored interrupt handling
// - no fpu bit traps floating instructions
// - no custom bit traps custom instructions
// - fast exception bit selects direct mode
// - data cache enable and lock controls
// - instruction cache enable and lock controls
// - configuration field layout as listed
// - condition bits enable; lanes pick bytes
// - address compare gated by kind enables
// - master enable and per-mode enables gate
// - trap enable raises debug trap
// - pc equal breakpoint flags pc match
// - condition register field layout as listed
// - single-step and branch-predict-disable outputs
// - detected conditions set status flags
// - read/write bit; both clears it
// - status layout bits 31 to 28
module ccd_cfg_debug
	import ccd_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_load_proc_reg_instr,
	input wire logic i_store_proc_reg_instr,
	input wire logic i_set_config_instr,
	input wire logic [2:0] i_reg_sel,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_short_field,
	output logic [31:0] o_rdata,
	input wire logic i_user_mode,
	input wire logic i_instr_done,
	input wire logic [31:0] i_pc,
	input wire logic i_ext_condition,
	input wire logic i_rd_ref,
	input wire logic i_wr_ref,
	input wire logic [31:0] i_ref_addr,
	input wire logic [3:0] i_ref_lanes,
	input wire logic i_fp_instr,
	input wire logic i_custom_instr,
	output logic o_vectored_irq,
	output logic o_fp_to_slave,
	output logic o_custom_to_slave,
	output logic o_undef_trap,
	output logic o_fast_exception_enable,
	output logic o_data_cache_enable,
	output logic o_data_cache_lock,
	output logic o_instr_cache_enable,
	output logic o_instr_cache_lock,
	output logic o_single_instr,
	output logic o_branch_predict_disable,
	output logic o_debug_event_trap
);
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] debug_condition_control;
		logic [31:0] dsr;
		logic [31:0] compare_address_value;
		logic [31:0] breakpoint_program_counter;
		logic [31:0] rdata;
		logic rw_seen_rd;
		logic rw_seen_wr;
	} ccd_state_s;

	ccd_state_s st_q;
	ccd_state_s st_d;
	logic [3:0] lane_hit;
	logic addr_eq;
	logic cond_live;
	logic rd_hit;
	logic wr_hit;
	logic ac_hit;
	logic pc_hit;
	logic ex_hit;
	logic wr_en;

	// double-word match on the upper address bits, lane granularity below
	assign addr_eq = (i_ref_addr[31:2] == st_q.compare_address_value[31:2]);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			ccd_lane_cmp u_lane (
				.i_en(st_q.debug_condition_control[DCR_BL0 + g]),
				.i_ref_lane(i_ref_lanes[g]),
				.i_addr_eq(addr_eq),
				.o_hit(lane_hit[g])
			);
		end
	endgenerate

	always_comb begin
		cond_live = st_q.debug_condition_control[DCR_DEN] &
			(i_user_mode ? st_q.debug_condition_control[DCR_UME] : st_q.debug_condition_control[DCR_SME]);
	end
	assign rd_hit = cond_live & st_q.debug_condition_control[DCR_ACE] & st_q.debug_condition_control[DCR_RDC] & i_rd_ref
		& (|lane_hit);
	assign wr_hit = cond_live & st_q.debug_condition_control[DCR_ACE] & st_q.debug_condition_control[DCR_WRC] & i_wr_ref
		& (|lane_hit);
	assign ac_hit = rd_hit | wr_hit;
	assign pc_hit = cond_live & st_q.debug_condition_control[DCR_PCE] & (i_pc == st_q.breakpoint_program_counter);
	assign ex_hit = cond_live & i_ext_condition;
	assign wr_en = i_load_proc_reg_instr;

	always_comb begin
		st_d = st_q;
		// software write first, so a hardware set in the same cycle wins
		if (wr_en) begin
			if (i_reg_sel == SEL_CFG) begin
				st_d.cfg = (i_wdata & CFG_WMASK) | CFG_ONES;
			end else if (i_reg_sel == SEL_DCR) begin
				st_d.debug_condition_control = i_wdata & DCR_WMASK;
			end else if (i_reg_sel == SEL_DSR) begin
				st_d.dsr = i_wdata & DSR_WMASK;
			end else if (i_reg_sel == SEL_CAR) begin
				st_d.compare_address_value = i_wdata;
			end else if (i_reg_sel == SEL_BPC) begin
				st_d.breakpoint_program_counter = i_wdata;
			end
		end
		if (i_set_config_instr) begin
			// bit 2 is reserved and stays zero regardless of the field
			st_d.cfg = CFG_ONES | {28'h0000000, i_short_field & 4'hb};
		end
		if (pc_hit) begin
			st_d.dsr[DSR_PCH] = 1'b1;
		end
		if (ex_hit) begin
			st_d.dsr[DSR_EXH] = 1'b1;
		end
		if (ac_hit) begin
			st_d.dsr[DSR_ACH] = 1'b1;
		end
		// per-instruction tracking of read and write hits
		if (rd_hit) begin
			st_d.rw_seen_rd = 1'b1;
		end
		if (wr_hit) begin
			st_d.rw_seen_wr = 1'b1;
		end
		if (ac_hit) begin
			st_d.dsr[DSR_RWI] = (st_q.rw_seen_rd | rd_hit) &
				~(st_q.rw_seen_wr | wr_hit);
		end
		if (i_instr_done) begin
			st_d.rw_seen_rd = 1'b0;
			st_d.rw_seen_wr = 1'b0;
		end
		st_d.rdata = st_q.rdata;
		if (i_store_proc_reg_instr) begin
			if (i_reg_sel == SEL_CFG) begin
				st_d.rdata = st_q.cfg | CFG_ONES;
			end else if (i_reg_sel == SEL_DCR) begin
				st_d.rdata = st_q.debug_condition_control;
			end else if (i_reg_sel == SEL_DSR) begin
				st_d.rdata = st_q.dsr;
			end else if (i_reg_sel == SEL_CAR) begin
				st_d.rdata = st_q.compare_address_value;
			end else if (i_reg_sel == SEL_BPC) begin
				st_d.rdata = st_q.breakpoint_program_counter;
			end else begin
				st_d.rdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_q <= '{cfg: CFG_RESET, debug_condition_control: DCR_RESET, dsr: DSR_RESET, compare_address_value: ADR_RESET,
				breakpoint_program_counter: ADR_RESET, rdata: 32'h0000_0000, rw_seen_rd: 1'b0, rw_seen_wr: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_vectored_irq = st_q.cfg[CFG_VEC];
	assign o_fp_to_slave = i_fp_instr & st_q.cfg[CFG_FPU];
	assign o_custom_to_slave = i_custom_instr & st_q.cfg[CFG_CUS];
	assign o_undef_trap = (i_fp_instr & ~st_q.cfg[CFG_FPU]) |
		(i_custom_instr & ~st_q.cfg[CFG_CUS]);
	assign o_fast_exception_enable = st_q.cfg[CFG_FEX];
	assign o_data_cache_enable = st_q.cfg[CFG_DCE];
	assign o_data_cache_lock = st_q.cfg[CFG_DCL];
	assign o_instr_cache_enable = st_q.cfg[CFG_ICE];
	assign o_instr_cache_lock = st_q.cfg[CFG_ICL];
	assign o_single_instr = st_q.debug_condition_control[DCR_SGL];
	assign o_branch_predict_disable = st_q.debug_condition_control[DCR_BPD];
	// trap is combinational so it lands on the offending instruction
	assign o_debug_event_trap = st_q.debug_condition_control[DCR_TRP] & (pc_hit | ex_hit | ac_hit);

	cfg_ones_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		st_q.cfg[7:4] == 4'hf) else $error("forced config ones lost");
	cfg_reserved_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		st_q.cfg[31:13] == 19'h0 && !st_q.cfg[2]) else $error("reserved cfg bit set");
	set_config_instr_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_set_config_instr |=> st_q.cfg[12:8] == 5'h0 && st_q.cfg[3] == $past(i_short_field[3]))
		else $error("set-config wrong");
	undef_trap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_fp_instr && !i_custom_instr |-> o_undef_trap != o_fp_to_slave)
		else $error("fp routing wrong");
	pc_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pc_hit |=> st_q.dsr[DSR_PCH]) else $error("pc hit not flagged");
	pc_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pc_hit |-> st_q.debug_condition_control[DCR_DEN] && i_pc == st_q.breakpoint_program_counter) else $error("pc hit ungated");
	acmp_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ac_hit |-> st_q.debug_condition_control[DCR_ACE] && (st_q.debug_condition_control[7:0] & 8'h0f) != 8'h0)
		else $error("address hit ungated");
	rw_both_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_hit && wr_hit |=> !st_q.dsr[DSR_RWI]) else $error("rw bit set on both");
	trap_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_debug_event_trap |-> st_q.debug_condition_control[DCR_TRP] && cond_live) else $error("trap ungated");
	flag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		st_q.dsr[DSR_ACH] && !(wr_en && i_reg_sel == SEL_DSR) |=> st_q.dsr[DSR_ACH])
		else $error("flag cleared by hardware");
endmodule : ccd_cfg_debug
`default_nettype wire

// ===== src/ccd_pkg.sv
package ccd_pkg;
	// processor-register selector on the load/store instruction port
	localparam logic [2:0] SEL_CFG = 3'h0;
	localparam logic [2:0] SEL_DCR = 3'h1;
	localparam logic [2:0] SEL_DSR = 3'h2;
	localparam logic [2:0] SEL_CAR = 3'h3;
	localparam logic [2:0] SEL_BPC = 3'h4;
	// configuration fields
	localparam int CFG_VEC = 0;
	localparam int CFG_FPU = 1;
	localparam int CFG_CUS = 3;
	localparam int CFG_FEX = 8;
	localparam int CFG_DCE = 9;
	localparam int CFG_DCL = 10;
	localparam int CFG_ICE = 11;
	localparam int CFG_ICL = 12;
	localparam logic [31:0] CFG_ONES = 32'h0000_00f0;
	localparam logic [31:0] CFG_WMASK = 32'h0000_1f0b;
	localparam logic [31:0] CFG_RESET = 32'h0000_00f0;
	// debug condition fields
	localparam int DCR_BL0 = 0;
	localparam int DCR_WRC = 5;
	localparam int DCR_RDC = 6;
	localparam int DCR_ACE = 7;
	localparam int DCR_SGL = 17;
	localparam int DCR_BPD = 18;
	localparam int DCR_TRP = 19;
	localparam int DCR_PCE = 20;
	localparam int DCR_UME = 21;
	localparam int DCR_SME = 22;
	localparam int DCR_DEN = 23;
	localparam logic [31:0] DCR_WMASK = 32'h00fe_00ef;
	localparam logic [31:0] DCR_RESET = 32'h0000_0000;
	// debug status fields
	localparam int DSR_RWI = 31;
	localparam int DSR_PCH = 30;
	localparam int DSR_EXH = 29;
	localparam int DSR_ACH = 28;
	localparam logic [31:0] DSR_WMASK = 32'hf000_0000;
	localparam logic [31:0] DSR_RESET = 32'h0000_0000;
	localparam logic [31:0] ADR_RESET = 32'h0000_0000;
endpackage : ccd_pkg

// ===== src/ccd_lane_cmp.sv
`timescale 1ns/1ns
`default_nettype none
// one byte lane of the compare-address match
module ccd_lane_cmp (
	input wire logic i_en,
	input wire logic i_ref_lane,
	input wire logic i_addr_eq,
	output logic o_hit
);
	assign o_hit = i_en & i_ref_lane & i_addr_eq;
endmodule : ccd_lane_cmp
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import ccd_pkg::*; ;
	logic i_clk_sys, i_rst = 1'h1, i_load_proc_reg_instr = '0, i_store_proc_reg_instr = '0;
	logic i_set_config_instr = '0, i_user_mode = '0, i_instr_done = '0, i_ext_condition = '0;
	logic i_rd_ref = '0, i_wr_ref = '0, i_fp_instr = '0, i_custom_instr = '0;
	logic [2:0] i_reg_sel = '0;
	logic [3:0] i_short_field = '0, i_ref_lanes = '0;
	logic [31:0] i_wdata = '0, i_pc = '0, i_ref_addr = '0, o_rdata;
	logic o_vectored_irq, o_fp_to_slave, o_custom_to_slave, o_undef_trap;
	logic o_fast_exception_enable, o_data_cache_enable, o_data_cache_lock;
	logic o_instr_cache_enable, o_instr_cache_lock, o_single_instr;
	logic o_branch_predict_disable, o_debug_event_trap;
	int err_total = 0, compares = 0, seed = 45;
	// reference copy of the five registers and their writable bits
	logic [31:0] m [5] = '{32'hf0, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0] msk [5] = '{32'h1f0b, 32'h00fe_00ef, 32'hf000_0000, 32'hffff_ffff, 32'hffff_ffff};
	logic wseen = 1'h0;
	ccd_cfg_debug u_dut (.*);
	initial begin
		i_clk_sys = 1'h0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic ld(logic [2:0] s, logic [31:0] v);
		@(posedge i_clk_sys);
		i_load_proc_reg_instr <= 1'h1;
		i_reg_sel <= s;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_load_proc_reg_instr <= 1'h0;
		if (s < 5) m[s] = v & msk[s] | (s == 0 ? 32'hf0 : 32'h0);
	endtask : ld
	task automatic rd(logic [2:0] s);
		@(posedge i_clk_sys);
		i_store_proc_reg_instr <= 1'h1;
		i_reg_sel <= s;
		@(posedge i_clk_sys);
		i_store_proc_reg_instr <= 1'h0;
		@(negedge i_clk_sys);
		chk("rdata", o_rdata, s < 5 ? m[s] : 32'h0);
	endtask : rd
	task automatic outs;
		@(negedge i_clk_sys);
		chk("cfg_out", {o_instr_cache_lock, o_instr_cache_enable, o_data_cache_lock,
			o_data_cache_enable, o_fast_exception_enable, o_vectored_irq},
			{m[0][12:8], m[0][0]});
		chk("dcr_out", {o_branch_predict_disable, o_single_instr}, m[1][18:17]);
		chk("undef", o_undef_trap, i_fp_instr & !m[0][1] | i_custom_instr & !m[0][3]);
		chk("slave", {o_fp_to_slave, o_custom_to_slave},
			{i_fp_instr & m[0][1], i_custom_instr & m[0][3]});
	endtask : outs
	task automatic sc(logic [3:0] f);
		@(posedge i_clk_sys);
		i_set_config_instr <= 1'h1;
		i_short_field <= f;
		@(posedge i_clk_sys);
		i_set_config_instr <= 1'h0;
		i_fp_instr <= seed[0];
		i_custom_instr <= seed[1];
		m[0] = 32'hf0 | f;
	endtask : sc
	task automatic rf;
		logic [31:0] v, a, pc;
		logic g, ac, ph, ex;
		v = $random(seed);
		// half the references land inside the compared double-word
		a = v[10] ? m[3] | v[12:11] : $random(seed);
		pc = v[13] ? m[4] : 32'h0;
		@(posedge i_clk_sys);
		{i_rd_ref, i_wr_ref, i_user_mode, i_ext_condition, i_instr_done} <= {v[3:0], 1'h0};
		i_ref_lanes <= v[9:6];
		i_ref_addr <= a;
		i_pc <= pc;
		g = m[1][23] && (v[1] ? m[1][21] : m[1][22]);
		ac = g && m[1][7] && (v[3] && m[1][6] || v[2] && m[1][5]) && a[31:2] == m[3][31:2]
			&& |(v[9:6] & m[1][3:0]);
		ph = g && m[1][20] && pc == m[4];
		ex = g && v[0];
		@(negedge i_clk_sys);
		chk("trap", o_debug_event_trap, m[1][19] && (ac || ph || ex));
		@(posedge i_clk_sys);
		{i_rd_ref, i_wr_ref, i_ext_condition, i_instr_done} <= {3'h0, v[5]};
		i_pc <= 32'h0;
		if (ac) begin
			wseen = wseen | v[2] & m[1][5];
			m[2][31] = !wseen;
		end
		m[2][30:28] = m[2][30:28] | {ph, ex, ac};
		if (v[5]) wseen = 1'h0;
	endtask : rf
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'h0;
		outs;
		for (int s = 0; s < 8; s++) rd(3'(s));
		for (int s = 0; s < 5; s++) begin
			ld(3'(s), $random(seed));
			rd(3'(s));
		end
		ld(3'h7, $random(seed));
		for (int s = 0; s < 5; s++) rd(3'(s));
		for (int i = 0; i < 16; i++) begin
			ld(SEL_CFG, $random(seed) & 32'h1f0b);
			outs;
			sc(4'(i) & 4'hb);
			outs;
			rd(SEL_CFG);
		end
		ld(SEL_CAR, $random(seed) & 32'hffff_fffc);
		ld(SEL_BPC, $random(seed) | 32'h100);
		for (int k = 0; k < 96; k++) begin
			if (k % 8 == 0) begin
				ld(SEL_DSR, 32'h0);
				ld(SEL_DCR, $random(seed) | (k < 64 ? 32'h00f8_00e0 : 32'h0));
			end
			rf;
			rd(SEL_DSR);
		end
		outs;
		tally_and_finish;
	end
	initial begin
		#100000;
		err_total++;
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
